/* inc/iab_pkg.sv */
// package for the i2c own-address and bit-rate block
// holds register offsets, field layout, rate table and the command set;
// assumes a 32-bit avalon-mm register bus with word-aligned offsets
package iab_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_OWN_ADDR = 4'h0;  // own_slave_address
    localparam logic [3:0] OFS_DIVIDER  = 4'h4;  // bit_rate_divider
    localparam logic [3:0] OFS_STATUS   = 4'h8;  // engine status, ro
    localparam logic [7:0] RST_OWN_ADDR = 8'h00; // reset values
    localparam logic [7:0] RST_DIVIDER  = 8'h00;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int ADDR_LSB = 1;                  // address in bits 7:1
    localparam int ADDR_MSB = 7;
    localparam int CODE_LSB = 0;                  // clock_rate_code 5:0
    localparam int CODE_MSB = 5;
    localparam int RATE_MULTIPLIER_LSB = 6;                  // rate_multiplier 7:6
    localparam int RATE_MULTIPLIER_MSB = 7;
    localparam logic [1:0] RATE_MULTIPLIER_X1 = 2'h0;        // shift amounts
    localparam logic [1:0] RATE_MULTIPLIER_X2 = 2'h1;
    localparam logic [1:0] RATE_MULTIPLIER_X4 = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CMD_START, CMD_BIT, CMD_STOP} iab_cmd_t;

    typedef struct packed {
        logic [11:0] div;   // scl divider
        logic [9:0]  sda;   // sda hold value
        logic [10:0] sta;   // scl start hold value
        logic [10:0] stp;   // scl stop hold value
    } iab_rate_t;

    // rate code to divider and hold values
    function automatic iab_rate_t iab_rate_lookup(input logic [5:0] c);
        logic [43:0] r;
        case (c)
            6'h00: r = {12'h014, 10'h007, 11'h006, 11'h00B};
            6'h01: r = {12'h016, 10'h007, 11'h007, 11'h00C};
            6'h02: r = {12'h018, 10'h008, 11'h008, 11'h00D};
            6'h03: r = {12'h01A, 10'h008, 11'h009, 11'h00E};
            6'h04: r = {12'h01C, 10'h009, 11'h00A, 11'h00F};
            6'h05: r = {12'h01E, 10'h009, 11'h00B, 11'h010};
            6'h06: r = {12'h022, 10'h00A, 11'h00D, 11'h012};
            6'h07: r = {12'h028, 10'h00A, 11'h010, 11'h015};
            6'h08: r = {12'h01C, 10'h007, 11'h00A, 11'h00F};
            6'h09: r = {12'h020, 10'h007, 11'h00C, 11'h011};
            6'h0A: r = {12'h024, 10'h009, 11'h00E, 11'h013};
            6'h0B: r = {12'h028, 10'h009, 11'h010, 11'h015};
            6'h0C: r = {12'h02C, 10'h00B, 11'h012, 11'h017};
            6'h0D: r = {12'h030, 10'h00B, 11'h014, 11'h019};
            6'h0E: r = {12'h038, 10'h00D, 11'h018, 11'h01D};
            6'h0F: r = {12'h044, 10'h00D, 11'h01E, 11'h023};
            6'h10: r = {12'h030, 10'h009, 11'h012, 11'h019};
            6'h11: r = {12'h038, 10'h009, 11'h016, 11'h01D};
            6'h12: r = {12'h040, 10'h00D, 11'h01A, 11'h021};
            6'h13: r = {12'h048, 10'h00D, 11'h01E, 11'h025};
            6'h14: r = {12'h050, 10'h011, 11'h022, 11'h029};
            6'h15: r = {12'h058, 10'h011, 11'h026, 11'h02D};
            6'h16: r = {12'h068, 10'h015, 11'h02E, 11'h035};
            6'h17: r = {12'h080, 10'h015, 11'h03A, 11'h041};
            6'h18: r = {12'h050, 10'h009, 11'h026, 11'h029};
            6'h19: r = {12'h060, 10'h009, 11'h02E, 11'h031};
            6'h1A: r = {12'h070, 10'h011, 11'h036, 11'h039};
            6'h1B: r = {12'h080, 10'h011, 11'h03E, 11'h041};
            6'h1C: r = {12'h090, 10'h019, 11'h046, 11'h049};
            6'h1D: r = {12'h0A0, 10'h019, 11'h04E, 11'h051};
            6'h1E: r = {12'h0C0, 10'h021, 11'h05E, 11'h061};
            6'h1F: r = {12'h0F0, 10'h021, 11'h076, 11'h079};
            6'h20: r = {12'h0A0, 10'h011, 11'h04E, 11'h051};
            6'h21: r = {12'h0C0, 10'h011, 11'h05E, 11'h061};
            6'h22: r = {12'h0E0, 10'h021, 11'h06E, 11'h071};
            6'h23: r = {12'h100, 10'h021, 11'h07E, 11'h081};
            6'h24: r = {12'h120, 10'h031, 11'h08E, 11'h091};
            6'h25: r = {12'h140, 10'h031, 11'h09E, 11'h0A1};
            6'h26: r = {12'h180, 10'h041, 11'h0BE, 11'h0C1};
            6'h27: r = {12'h1E0, 10'h041, 11'h0EE, 11'h0F1};
            6'h28: r = {12'h140, 10'h021, 11'h09E, 11'h0A1};
            6'h29: r = {12'h180, 10'h021, 11'h0BE, 11'h0C1};
            6'h2A: r = {12'h1C0, 10'h041, 11'h0DE, 11'h0E1};
            6'h2B: r = {12'h200, 10'h041, 11'h0FE, 11'h101};
            6'h2C: r = {12'h240, 10'h061, 11'h11E, 11'h121};
            6'h2D: r = {12'h280, 10'h061, 11'h13E, 11'h141};
            6'h2E: r = {12'h300, 10'h081, 11'h17E, 11'h181};
            6'h2F: r = {12'h3C0, 10'h081, 11'h1DE, 11'h1E1};
            6'h30: r = {12'h280, 10'h041, 11'h13E, 11'h141};
            6'h31: r = {12'h300, 10'h041, 11'h17E, 11'h181};
            6'h32: r = {12'h380, 10'h081, 11'h1BE, 11'h1C1};
            6'h33: r = {12'h400, 10'h081, 11'h1FE, 11'h201};
            6'h34: r = {12'h480, 10'h0C1, 11'h23E, 11'h241};
            6'h35: r = {12'h500, 10'h0C1, 11'h27E, 11'h281};
            6'h36: r = {12'h600, 10'h101, 11'h2FE, 11'h301};
            6'h37: r = {12'h780, 10'h101, 11'h3BE, 11'h3C1};
            6'h38: r = {12'h500, 10'h081, 11'h27E, 11'h281};
            6'h39: r = {12'h600, 10'h081, 11'h2FE, 11'h301};
            6'h3A: r = {12'h700, 10'h101, 11'h37E, 11'h381};
            6'h3B: r = {12'h800, 10'h101, 11'h3FE, 11'h401};
            6'h3C: r = {12'h900, 10'h181, 11'h47E, 11'h481};
            6'h3D: r = {12'hA00, 10'h181, 11'h4FE, 11'h501};
            6'h3E: r = {12'hC00, 10'h201, 11'h5FE, 11'h601};
            default: r = {12'hF00, 10'h201, 11'h77E, 11'h781};
        endcase
        return iab_rate_t'(r);
    endfunction : iab_rate_lookup

endpackage : iab_pkg

/* rtl/iab_core.sv */
// own slave address store and scl/sda timing engine of the i2c block
// assumes a single 100 MHz bus clock, an avalon-mm master on the
// register side and open-drain scl/sda resolved outside this module
//
// Our own choices: the register offsets and the Avalon-MM register port.
module iab_core (
    input  wire logic        i_clk,         // bus clock, 100 MHz
    input  wire logic        i_resetn,      // sync reset, active low
    input  wire logic [3:0]  i_address,     // avalon byte address
    input  wire logic        i_read,        // avalon read
    input  wire logic        i_write,       // avalon write
    input  wire logic [31:0] i_writedata,   // avalon write data
    input  wire logic [3:0]  i_byteenable,  // avalon byte enables
    output logic      [31:0] o_readdata,    // avalon read data
    output logic             o_waitrequest, // avalon wait
    input  wire logic        i_cmd_valid,   // engine command strobe
    input  wire logic [1:0]  i_cmd,         // iab_cmd_t code
    input  wire logic        i_cmd_bit,     // bit to send, 1 = release
    output logic             o_cmd_ready,   // engine can take command
    output logic             o_rx_bit,      // sda sampled at scl high
    output logic      [6:0]  o_own_addr,    // own slave address
    input  wire logic        i_scl,         // scl pin level
    output logic             o_scl,         // scl output value
    output logic             o_scl_oe,      // high: pull scl low
    input  wire logic        i_sda,         // sda pin level
    output logic             o_sda,         // sda output value
    output logic             o_sda_oe       // high: pull sda low
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_STA_HOLD, S_PARK, S_LOW_HOLD, S_LOW_REST,
        S_HIGH, S_STP_HOLD
    } iab_state_t;

    iab_state_t       st_q, st_d;        // engine state
    logic [7:0]       addr_q;            // own_slave_address
    logic [7:0]       div_q;             // bit_rate_divider
    logic             ack_q;             // bus answer cycle
    logic [31:0]      rdata_q;           // read data flop
    logic [15:0]      cnt_q, cnt_d;      // phase down-counter
    logic             stop_q;            // low phase ends in stop
    logic             bit_q;             // bit being sent
    logic             sda_oe_q;          // sda pull-down
    logic             scl_oe_q;          // scl pull-down
    logic             rx_q;              // received bit
    logic [1:0]       scl_s_q, sda_s_q;  // pin synchronisers

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        req_w   = i_read | i_write;
    wire        wr_w    = i_write & ack_q & i_byteenable[0];
    wire        hit_a_w = i_address == iab_pkg::OFS_OWN_ADDR;
    wire        hit_d_w = i_address == iab_pkg::OFS_DIVIDER;
    wire        hit_s_w = i_address == iab_pkg::OFS_STATUS;
    wire [7:0]  stat_w  = {4'h0, rx_q, sda_s_q[1], scl_s_q[1],
                           o_cmd_ready};
    // unmapped offsets read zero, writes to them are dropped
    wire [7:0]  rsel_w  = hit_a_w ? addr_q :
                          hit_d_w ? div_q  :
                          hit_s_w ? stat_w : 8'h00;

    // every access answers after exactly one wait cycle
    assign o_waitrequest = req_w & ~ack_q;
    assign o_readdata    = rdata_q;

    // ------------------------------------------------------------
    // rate selection
    // ------------------------------------------------------------
    wire [5:0]  code_w = div_q[iab_pkg::CODE_MSB:iab_pkg::CODE_LSB];
    wire [1:0]  rate_multiplier_w = div_q[iab_pkg::RATE_MULTIPLIER_MSB:iab_pkg::RATE_MULTIPLIER_LSB];
    // reserved multiplier encoding falls back to x1
    wire [1:0]  sh_w   = (rate_multiplier_w == iab_pkg::RATE_MULTIPLIER_X2) ? 2'h1 :
                         (rate_multiplier_w == iab_pkg::RATE_MULTIPLIER_X4) ? 2'h2 : 2'h0;
    wire iab_pkg::iab_rate_t rate_w = iab_pkg::iab_rate_lookup(code_w);
    // table values scaled by the multiplier
    wire [15:0] per_w  = 16'({4'h0, rate_w.div} << sh_w);
    wire [15:0] half_w = per_w >> 1;
    wire [15:0] sdah_w = 16'({6'h00, rate_w.sda} << sh_w);
    wire [15:0] stah_w = 16'({5'h00, rate_w.sta} << sh_w);
    wire [15:0] stph_w = 16'({5'h00, rate_w.stp} << sh_w);
    // rest of low phase, never below one cycle
    wire [15:0] rest_w = (half_w > sdah_w) ? half_w - sdah_w : 16'h0001;
    wire        done_w = cnt_q == 16'h0000;
    wire        take_w = i_cmd_valid & o_cmd_ready;

    assign o_cmd_ready = (st_q == S_IDLE) | (st_q == S_PARK);
    assign o_own_addr  = addr_q[iab_pkg::ADDR_MSB:iab_pkg::ADDR_LSB];
    assign o_scl       = 1'b0;
    assign o_sda       = 1'b0;
    assign o_scl_oe    = scl_oe_q;
    assign o_sda_oe    = sda_oe_q;
    assign o_rx_bit    = rx_q;

    // ------------------------------------------------------------
    // registers and bus answer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            addr_q  <= iab_pkg::RST_OWN_ADDR;
            div_q   <= iab_pkg::RST_DIVIDER;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req_w & ~ack_q;
            rdata_q <= {24'h00_0000, rsel_w};
            if (wr_w && hit_a_w) begin
                addr_q <= i_writedata[7:0];
            end
            if (wr_w && hit_d_w) begin
                div_q <= i_writedata[7:0];
            end
        end
    end

    // pins come from outside: two flops before any use
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
        end else begin
            scl_s_q <= {scl_s_q[0], i_scl};
            sda_s_q <= {sda_s_q[0], i_sda};
        end
    end

    // ------------------------------------------------------------
    // timing engine, next state
    // ------------------------------------------------------------
    always_comb begin
        st_d  = st_q;
        cnt_d = done_w ? cnt_q : cnt_q - 16'h0001;
        case (st_q)
            S_IDLE: begin
                if (take_w && i_cmd == iab_pkg::CMD_START) begin
                    st_d  = S_STA_HOLD;
                    cnt_d = stah_w - 16'h0001;
                end
            end
            S_STA_HOLD: begin
                if (done_w) begin
                    st_d = S_PARK;
                end
            end
            S_PARK: begin
                if (take_w && i_cmd != iab_pkg::CMD_START) begin
                    st_d  = S_LOW_HOLD;
                    cnt_d = sdah_w - 16'h0001;
                end
            end
            S_LOW_HOLD: begin
                if (done_w) begin
                    st_d  = S_LOW_REST;
                    cnt_d = rest_w - 16'h0001;
                end
            end
            S_LOW_REST: begin
                if (done_w) begin
                    st_d  = stop_q ? S_STP_HOLD : S_HIGH;
                    cnt_d = (stop_q ? stph_w : half_w) - 16'h0001;
                end
            end
            S_HIGH: begin
                if (done_w) begin
                    st_d = S_PARK;
                end
            end
            S_STP_HOLD: begin
                if (done_w) begin
                    st_d = S_IDLE;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    // state, counter and pin drive; pins follow the state change
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st_q     <= S_IDLE;
            cnt_q    <= 16'h0000;
            stop_q   <= 1'b0;
            bit_q    <= 1'b1;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            rx_q     <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            if (take_w) begin
                stop_q <= i_cmd == iab_pkg::CMD_STOP;
                bit_q  <= i_cmd_bit;
            end
            // sda changes only here: at the start take, or once a low or stop hold has run out
            if (st_q == S_IDLE && st_d == S_STA_HOLD) begin
                sda_oe_q <= 1'b1;
            end else if (st_q == S_LOW_HOLD && done_w) begin
                sda_oe_q <= stop_q | ~bit_q;
            end else if (st_q == S_STP_HOLD && done_w) begin
                sda_oe_q <= 1'b0;
            end
            // scl low in park and in the low hold and low rest phases
            scl_oe_q <= (st_d == S_PARK) | (st_d == S_LOW_HOLD) |
                        (st_d == S_LOW_REST);
            if (st_q == S_HIGH && done_w) begin
                rx_q <= sda_s_q[1];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] hi_cnt_q;   // cycles spent in the current phase
    always_ff @(posedge i_clk) begin
        if (!i_resetn || st_q != st_d) begin
            hi_cnt_q <= 16'h0000;
        end else begin
            hi_cnt_q <= hi_cnt_q + 16'h0001;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    AST_ADDR_STORE: assert property (
        (ack_q && i_write && i_byteenable[0] && hit_a_w) |=>
        o_own_addr == $past(i_writedata[7:1]))
        else $error("own address not taken from bits 7:1");
    AST_CODE_FIELD: assert property (
        (ack_q && i_write && i_byteenable[0] && hit_d_w) |=>
        code_w == $past(i_writedata[5:0]) &&
        rate_multiplier_w == $past(i_writedata[7:6]))
        else $error("rate code not taken from bits 5:0");
    AST_HIGH_LEN: assert property (
        (st_q == S_HIGH && done_w) |-> hi_cnt_q == half_w - 16'h0001)
        else $error("scl high phase is not half the period");
    AST_SDA_HOLD: assert property (
        (st_q == S_LOW_HOLD && !done_w) |=> $stable(o_sda_oe))
        else $error("sda changed inside the hold time");
    AST_START: assert property (
        (st_q == S_STA_HOLD && done_w) |->
        hi_cnt_q == stah_w - 16'h0001 && o_sda_oe && !o_scl_oe
        ##1 o_scl_oe)
        else $error("start hold wrong");
    AST_STOP: assert property (
        (st_q == S_STP_HOLD && done_w) |->
        hi_cnt_q == stph_w - 16'h0001 && !o_scl_oe && o_sda_oe
        ##1 !o_sda_oe)
        else $error("stop hold wrong");
    AST_CODE00: assert property (
        (code_w == 6'h00) |-> rate_w.div == 12'h014 &&
        rate_w.sda == 10'h007 && rate_w.sta == 11'h006)
        else $error("code 00 values wrong");
    AST_CODE3F: assert property (
        (code_w == 6'h3F) |-> rate_w.div == 12'hF00 &&
        rate_w.stp == 11'h781)
        else $error("code 3F values wrong");
    AST_RATE_MULTIPLIER: assert property (
        (rate_multiplier_w == iab_pkg::RATE_MULTIPLIER_X4) |-> per_w == {rate_w.div, 2'h0})
        else $error("x4 multiplier not applied");

    COV_START: cover property (st_q == S_STA_HOLD ##1 st_q == S_PARK);
    COV_BIT:   cover property (st_q == S_HIGH ##1 st_q == S_PARK);
    COV_STOP:  cover property (st_q == S_STP_HOLD ##1 st_q == S_IDLE);

endmodule : iab_core

/* sim/iab_core_tb.sv */
// self-checking bench for the own-address and bit-rate block
// assumes the peer model resolves the open-drain lines
module iab_core_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // rows: codes 00, 1F, 20, 3F
    localparam logic [5:0] CODES [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
    localparam int DIVS [4] = '{16'h0014, 16'h00F0, 16'h00A0, 16'h0F00};
    localparam int SDAH [4] = '{16'h0007, 16'h0021, 16'h0011, 16'h0201};
    localparam int STAH [4] = '{16'h0006, 16'h0076, 16'h004E, 16'h077E};
    localparam int STPH [4] = '{16'h000B, 16'h0079, 16'h0051, 16'h0781};

    logic        i_clk, i_resetn, i_read, i_write, i_cmd_valid, i_cmd_bit;
    logic [3:0]  i_address, i_byteenable;
    logic [31:0] i_writedata, o_readdata;
    logic [1:0]  i_cmd;
    logic        o_waitrequest, o_cmd_ready, o_rx_bit, ack_en;
    logic [6:0]  o_own_addr;
    logic        scl, sda, o_scl, o_sda, o_scl_oe, o_sda_oe;
    int          errors = 0;
    int          samples_checked = 0;

    iab_core iab_core_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_bit(i_cmd_bit),
        .o_cmd_ready(o_cmd_ready), .o_rx_bit(o_rx_bit),
        .o_own_addr(o_own_addr), .i_scl(scl), .o_scl(o_scl),
        .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));

    iab_peer iab_peer_i (.i_clk(i_clk), .i_scl_oe(o_scl_oe),
        .i_sda_oe(o_sda_oe), .i_ack_en(ack_en), .o_scl(scl), .o_sda(sda));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // avalon access: held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] rd);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= {24'h000000, d};
        i_byteenable <= be;
        i_write <= wr;
        i_read <= ~wr;
        // no local limit: only the watchdog ends a stuck wait
        do begin
            @(posedge i_clk);
        end while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus

    // returns at the edge that takes the command
    task automatic send(input logic [1:0] c, input logic b);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_cmd_bit <= b;
        do begin
            @(posedge i_clk);
        end while (o_cmd_ready !== 1'b1);
        i_cmd_valid <= 1'b0;
    endtask : send

    // counts edges until the chosen oe reaches lvl
    task automatic wait_sig(input logic on_sda, input logic lvl,
                            output int n);
        logic s;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
            s = on_sda ? o_sda_oe : o_scl_oe;
        end while (s !== lvl);
    endtask : wait_sig

    task automatic finish_test();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        bus(1'b0, iab_pkg::OFS_OWN_ADDR, 8'h00, 4'hF, rd);
        check(rd, {24'h000000, iab_pkg::RST_OWN_ADDR});
        bus(1'b0, iab_pkg::OFS_DIVIDER, 8'h00, 4'hF, rd);
        check(rd, {24'h000000, iab_pkg::RST_DIVIDER});
        bus(1'b1, iab_pkg::OFS_OWN_ADDR, 8'hA5, 4'hF, rd);
        // lane 0 off: the write must be dropped
        bus(1'b1, iab_pkg::OFS_OWN_ADDR, 8'h3C, 4'hE, rd);
        bus(1'b0, iab_pkg::OFS_OWN_ADDR, 8'h00, 4'hF, rd);
        check(rd, 32'h000000A5);
        check({25'h0000000, o_own_addr}, 32'h00000052);
        bus(1'b1, iab_pkg::OFS_DIVIDER, 8'h9F, 4'hF, rd);
        bus(1'b0, iab_pkg::OFS_DIVIDER, 8'h00, 4'hF, rd);
        check(rd, 32'h0000009F);
        bus(1'b0, 4'hC, 8'h00, 4'hF, rd);
        check(rd, 32'h00000000);
        // idle engine: ready, both lines high, no bit received yet
        bus(1'b0, iab_pkg::OFS_STATUS, 8'h00, 4'hF, rd);
        check(rd, 32'h00000007);
        $display("test regs done");
    endtask : t_regs

    // start, released bit, low bit, stop at one rate setting
    task automatic t_frame(input int r, input logic [1:0] m,
                           input logic ack);
        logic [31:0] rd;
        int f, a, b, c;
        f = (m == 2'h1) ? 2 : (m == 2'h2) ? 4 : 1;
        bus(1'b1, iab_pkg::OFS_DIVIDER, {m, CODES[r]}, 4'hF, rd);
        ack_en <= ack;
        send(2'h0, 1'b0);
        wait_sig(1'b1, 1'b1, a);
        check({31'h0, o_scl_oe}, 32'h0);
        wait_sig(1'b0, 1'b1, b);
        // sda falls at the take edge, so count from there
        check(a, 1);
        check(a + b, STAH[r] * f);
        check({30'h0, o_scl, o_sda}, 32'h0);
        send(2'h1, 1'b1);
        wait_sig(1'b1, 1'b0, a);
        wait_sig(1'b0, 1'b0, b);
        wait_sig(1'b0, 1'b1, c);
        check(a, SDAH[r] * f);
        check(c, DIVS[r] * f / 2);
        check(a + b + c, DIVS[r] * f);
        @(posedge i_clk);
        #1;
        check({31'h0, o_rx_bit}, {31'h0, ~ack});
        send(2'h1, 1'b0);
        wait_sig(1'b1, 1'b1, a);
        check(a, SDAH[r] * f);
        wait_sig(1'b0, 1'b0, b);
        wait_sig(1'b0, 1'b1, c);
        ack_en <= 1'b0;
        send(2'h2, 1'b0);
        wait_sig(1'b0, 1'b0, a);
        wait_sig(1'b1, 1'b0, b);
        check(b, STPH[r] * f);
        check({31'h0, o_scl_oe}, 32'h0);
        $display("test frame %0d rate_multiplier %0d done", r, m);
    endtask : t_frame

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        i_resetn = 1'b0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = 4'h0;
        i_writedata = 32'h00000000;
        i_byteenable = 4'hF;
        i_cmd_valid = 1'b0;
        i_cmd = 2'h0;
        i_cmd_bit = 1'b0;
        ack_en = 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_frame(0, 2'h0, 1'b1);
        t_frame(0, 2'h1, 1'b0);
        t_frame(0, 2'h2, 1'b1);
        t_frame(0, 2'h3, 1'b0); // reserved multiplier acts as x1
        t_frame(1, 2'h1, 1'b1);
        t_frame(2, 2'h2, 1'b0);
        t_frame(3, 2'h0, 1'b1);
        finish_test();
    end

    // whole run is about 18k cycles; this cuts a hang well after that
    initial begin
        #900000;
        errors++;
        finish_test();
    end
endmodule : iab_core_tb

/* sim/iab_peer.sv */
// far-side i2c device: pull-ups on scl/sda plus a slave that can ack
// assumes the block's oe outputs pull a line low while high
module iab_peer (
    input  wire logic i_clk,    // bus clock
    input  wire logic i_scl_oe, // block pulls scl low
    input  wire logic i_sda_oe, // block pulls sda low
    input  wire logic i_ack_en, // slave should hold sda low
    output logic      o_scl,    // resolved scl level
    output logic      o_sda     // resolved sda level
);
    timeunit 1ns;
    timeprecision 1ns;

    logic pull_q; // slave pulls sda low

    // ------------------------------------------------------------
    // slave drive
    // ------------------------------------------------------------
    // moves only while scl is low, so it never fakes a start or stop
    always @(posedge i_clk) begin
        if (o_scl !== 1'b1) begin
            pull_q <= i_ack_en;
        end
    end

    // released lines rise through the pull-ups
    assign o_scl = ~i_scl_oe;
    assign o_sda = ~(i_sda_oe | (pull_q === 1'b1));
endmodule : iab_peer
